// ---- drop_event_report.sv ----
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
module drop_event_report
  import drop_event_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic hsel_in,
  input wire logic [drop_event_pkg::ADDR_W-1:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [drop_event_pkg::DATA_W-1:0] hwdata_in,
  input wire logic hready_in,
  output logic [drop_event_pkg::DATA_W-1:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic drop_valid_in,
  input wire logic [drop_event_pkg::CAUSE_W-1:0] drop_cause_in,
  input wire logic [1:0] drop_port_in,
  input wire logic [drop_event_pkg::LEN_W-1:0] drop_len_in,
  output logic irq_out
);

  import drop_event_pkg::*;

  typedef struct packed {
    bus_state_t bus;
    logic [13:0] idx;
    logic mask;
    logic red_en;
    logic yellow_en;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic irq;
  } top_state_t;

  top_state_t state_reg;
  top_state_t state_next;
  logic [31:0] count;
  logic [PEND_W-1:0] pend;
  logic take;
  logic rd_take;
  logic [13:0] addr_idx;
  logic count_clear;
  logic pend_clear;
  logic [CAUSE_W-1:0] cause_ok;
  logic [CAUSE_W-1:0] cause_en;
  logic drop_event;
  logic rate_inc;
  logic [3:0] drop_reason;
  logic pend_any;
  logic [DATA_W-1:0] read_word;

  // ---------------------------------------------------------------------------
  // cause qualification and reason encoding
  // ---------------------------------------------------------------------------
  function automatic logic [3:0] encode_reason(input logic [CAUSE_W-1:0] causes);
    logic [3:0] code;
    code = REASON_BCAST_LEVEL;
    for (int i = CAUSE_W - 1; i >= 0; i--) begin
      if (causes[i]) begin
        code = REASON_TABLE[i*4 +: 4];
      end
    end
    return code;
  endfunction

  always_comb begin
    cause_en = '1;
    cause_en[CAUSE_RED] = state_reg.red_en;
    cause_en[CAUSE_YELLOW] = state_reg.yellow_en;
    cause_en[CAUSE_RX_ERROR] = (drop_len_in > RX_ERR_MIN_LEN);
  end

  assign cause_ok = drop_cause_in & cause_en;
  assign drop_event = drop_valid_in && (|cause_ok) && (drop_port_in != PORT_RESERVED);
  assign drop_reason = encode_reason(cause_ok);
  // port 2 red or yellow drops
  assign rate_inc = drop_valid_in && (drop_port_in == PORT_2) &&
    (cause_ok[CAUSE_RED] || cause_ok[CAUSE_YELLOW]);

  // ---------------------------------------------------------------------------
  // bus address phase decode
  // ---------------------------------------------------------------------------
  assign take = hsel_in && htrans_in[1] && hready_in && (hsize_in == HSIZE_WORD);
  assign rd_take = take && !hwrite_in;
  assign addr_idx = haddr_in[ADDR_W-1:2];
  assign count_clear = rd_take && (addr_idx == IDX_RATE_COUNT);
  assign pend_clear = rd_take && (addr_idx == IDX_PENDING);
  assign pend_any = pend[0] || pend[7];

  always_comb begin
    read_word = '0;
    case (addr_idx)
      IDX_RATE_COUNT: read_word = count;
      IDX_MASK: read_word[MASK_BIT] = state_reg.mask;
      IDX_PENDING: read_word[PEND_W-1:0] = pend;
      IDX_DROP_CTRL: begin
        read_word[RED_EN_BIT] = state_reg.red_en;
        read_word[YELLOW_EN_BIT] = state_reg.yellow_en;
      end
      default: read_word = '0;
    endcase
  end

  // ---------------------------------------------------------------------------
  // register file and bus state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.ready = 1'b1;
    if (state_reg.bus == BUS_WRITE) begin
      case (state_reg.idx)
        IDX_MASK: state_next.mask = hwdata_in[MASK_BIT];
        IDX_DROP_CTRL: begin
          state_next.red_en = hwdata_in[RED_EN_BIT];
          state_next.yellow_en = hwdata_in[YELLOW_EN_BIT];
        end
        default: state_next.mask = state_reg.mask;
      endcase
    end
    case (state_reg.bus)
      BUS_IDLE, BUS_READ, BUS_WRITE: begin
        if (take && hwrite_in) begin
          state_next.bus = BUS_WRITE;
        end else if (take) begin
          state_next.bus = BUS_READ;
        end else begin
          state_next.bus = BUS_IDLE;
        end
      end
      default: state_next.bus = BUS_IDLE;
    endcase
    state_next.idx = take ? addr_idx : state_reg.idx;
    if (rd_take) begin
      state_next.rdata = read_word;
    end
    state_next.irq = pend_any && !state_reg.mask;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= '{bus: BUS_IDLE, idx: '0, mask: MASK_RESET, red_en: 1'b0,
        yellow_en: 1'b0, rdata: '0, ready: 1'b1, irq: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign hrdata_out = state_reg.rdata;
  assign hreadyout_out = state_reg.ready;
  assign hresp_out = 1'b0;
  assign irq_out = state_reg.irq;

  // ---------------------------------------------------------------------------
  // counter and slots
  // ---------------------------------------------------------------------------
  rate_drop_counter rate_drop_counter_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .inc_in(rate_inc),
    .clear_in(count_clear),
    .count_out(count)
  );

  drop_slot_pair drop_slot_pair_i (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .event_in(drop_event),
    .reason_in(drop_reason),
    .port_in(drop_port_in),
    .clear_in(pend_clear),
    .pend_out(pend)
  );

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  sequence s_count_read;
    count_clear && !rate_inc;
  endsequence

  sequence s_slot_a_free_event;
    drop_event && !pend[0] && !pend_clear;
  endsequence

  sequence s_slot_b_free_event;
    drop_event && pend[0] && !pend[7] && !pend_clear;
  endsequence

  a_count_step: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rate_inc && !count_clear && (count != COUNT_MAX) |=> count == $past(count) + COUNT_ONE)
    else $error("drop counter did not step");

  a_count_read_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_count_read |=> (count == COUNT_RESET) && (hrdata_out == $past(count)))
    else $error("counter read did not clear or return value");

  a_count_saturate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (count == COUNT_MAX) && !count_clear |=> count == COUNT_MAX)
    else $error("drop counter wrapped");

  a_mask_blocks_irq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    state_reg.mask |=> !irq_out)
    else $error("interrupt raised while masked");

  a_mask_write_bit: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_reg.bus == BUS_WRITE) && (state_reg.idx == IDX_MASK) |=>
      state_reg.mask == $past(hwdata_in[MASK_BIT]))
    else $error("mask bit not written");

  a_slot_a_fill: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_slot_a_free_event |=> pend[0] && (pend[6:3] == $past(drop_reason)) &&
      (pend[2:1] == $past(drop_port_in)))
    else $error("slot a not captured");

  a_slot_b_fill: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_slot_b_free_event |=> pend[7] && (pend[13:10] == $past(drop_reason)) &&
      (pend[9:8] == $past(drop_port_in)) && pend[0])
    else $error("slot b not captured");

  a_pend_read_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pend_clear && !drop_event |=> (pend == '0) && (hrdata_out[PEND_W-1:0] == $past(pend)))
    else $error("pending read did not clear");

  a_reserved_reason: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pend[0] |-> (pend[6:3] <= REASON_DROP_LEVEL) || (pend[6:3] == REASON_YELLOW))
    else $error("reserved reason recorded");

  a_port_valid: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pend[0] |-> pend[2:1] != PORT_RESERVED)
    else $error("reserved port recorded");

  a_irq_follows: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pend_any && !state_reg.mask |=> irq_out)
    else $error("unmasked interrupt missing");

  a_mask_keeps_status: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_reg.mask and s_slot_a_free_event) |=> pend[0] ##1 (pend[0] || $past(pend_clear)))
    else $error("status lost while masked");

  a_code_bcast: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && drop_cause_in[0] |=> pend[6:3] == REASON_BCAST_LEVEL)
    else $error("broadcast level code wrong");

  a_code_red: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && (drop_cause_in == 8'h02) |=> pend[6:3] == REASON_RED)
    else $error("red code wrong");

  a_code_buffer: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && (drop_cause_in == 8'h04) |=> pend[6:3] == REASON_NO_BUFFER)
    else $error("no buffer code wrong");

  a_code_desc: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && (drop_cause_in == 8'h08) |=> pend[6:3] == REASON_NO_DESC)
    else $error("no descriptor code wrong");

  a_code_no_dest: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && (drop_cause_in == 8'h10) |=> pend[6:3] == REASON_NO_DEST)
    else $error("no destination code wrong");

  a_code_rx_error: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && (drop_cause_in == 8'h20) |=> pend[6:3] == REASON_RX_ERROR)
    else $error("receive error code wrong");

  a_code_level: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && (drop_cause_in == 8'h40) |=> pend[6:3] == REASON_DROP_LEVEL)
    else $error("drop level code wrong");

  a_code_yellow: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_event && !pend[0] && (drop_cause_in == 8'h80) |=> pend[6:3] == REASON_YELLOW)
    else $error("yellow code wrong");

  a_red_gated: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (drop_cause_in == 8'h02) && !state_reg.red_en |-> !drop_event && !rate_inc)
    else $error("red drop taken while disabled");

  a_short_rx_error: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (drop_cause_in == 8'h20) && (drop_len_in <= RX_ERR_MIN_LEN) |-> !drop_event)
    else $error("short receive error recorded");

  a_reserved_port_drop: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    drop_port_in == PORT_RESERVED |-> !drop_event)
    else $error("reserved port event taken");

  a_slot_b_port: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pend[7] |-> pend[9:8] != PORT_RESERVED)
    else $error("reserved port in slot b");

  a_slot_b_reason: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pend[7] |-> (pend[13:10] <= REASON_DROP_LEVEL) || (pend[13:10] == REASON_YELLOW))
    else $error("reserved reason in slot b");

  a_slots_full_keep: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pend[0] && pend[7] && !pend_clear |=> pend == $past(pend))
    else $error("full slots overwritten");

  a_irq_quiet: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !pend_any |=> !irq_out)
    else $error("interrupt without pending flag");

  a_pend_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !drop_event && !pend_clear |=> $stable(pend))
    else $error("pending status changed on its own");

  a_count_clear_event: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    count_clear && rate_inc |=> count == COUNT_ONE)
    else $error("drop lost on counter read");

  a_count_other_port: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (drop_port_in != PORT_2) && !count_clear |=> count == $past(count))
    else $error("counter moved for other port");

endmodule

// ---- drop_event_pkg.sv ----
package drop_event_pkg;

  // ---------------------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------------------
  localparam logic [13:0] IDX_RATE_COUNT = 14'h1c18;
  localparam logic [13:0] IDX_MASK = 14'h1c20;
  localparam logic [13:0] IDX_PENDING = 14'h1c21;
  localparam logic [13:0] IDX_DROP_CTRL = 14'h1c22;

  // ---------------------------------------------------------------------------
  // widths, field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int PEND_W = 14;
  localparam int CAUSE_W = 8;
  localparam int LEN_W = 12;
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] COUNT_MAX = 32'hffff_ffff;
  localparam logic [31:0] COUNT_ONE = 32'h0000_0001;
  localparam logic MASK_RESET = 1'b1;
  localparam int MASK_BIT = 0;
  localparam int RED_EN_BIT = 0;
  localparam int YELLOW_EN_BIT = 1;
  localparam logic [LEN_W-1:0] RX_ERR_MIN_LEN = 12'h040;

  // ---------------------------------------------------------------------------
  // drop reasons, source ports, bus codes
  // ---------------------------------------------------------------------------
  localparam logic [3:0] REASON_BCAST_LEVEL = 4'h0;
  localparam logic [3:0] REASON_RED = 4'h1;
  localparam logic [3:0] REASON_NO_BUFFER = 4'h2;
  localparam logic [3:0] REASON_NO_DESC = 4'h3;
  localparam logic [3:0] REASON_NO_DEST = 4'h4;
  localparam logic [3:0] REASON_RX_ERROR = 4'h5;
  localparam logic [3:0] REASON_DROP_LEVEL = 4'h6;
  localparam logic [3:0] REASON_YELLOW = 4'h9;
  localparam int CAUSE_RED = 1;
  localparam int CAUSE_RX_ERROR = 5;
  localparam int CAUSE_YELLOW = 7;
  localparam logic [31:0] REASON_TABLE = {REASON_YELLOW, REASON_DROP_LEVEL, REASON_RX_ERROR,
    REASON_NO_DEST, REASON_NO_DESC, REASON_NO_BUFFER, REASON_RED, REASON_BCAST_LEVEL};
  localparam logic [1:0] PORT_2 = 2'b10;
  localparam logic [1:0] PORT_RESERVED = 2'b11;
  localparam logic [2:0] HSIZE_WORD = 3'b010;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_READ = 3'b010,
    BUS_WRITE = 3'b100
  } bus_state_t;

endpackage

// ---- rate_drop_counter.sv ----
`timescale 1ns/100ps
module rate_drop_counter
  import drop_event_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic inc_in,
  input wire logic clear_in,
  output logic [31:0] count_out
);

  typedef struct packed {
    logic [31:0] count;
  } cnt_state_t;

  cnt_state_t state_reg;
  cnt_state_t state_next;

  // ---------------------------------------------------------------------------
  // count, clear and saturate
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (clear_in) begin
      state_next.count = COUNT_RESET;
    end
    if (inc_in && (state_next.count != COUNT_MAX)) begin
      state_next.count = state_next.count + COUNT_ONE;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= '{count: COUNT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign count_out = state_reg.count;

endmodule

// ---- drop_slot_pair.sv ----
`timescale 1ns/100ps
module drop_slot_pair
  import drop_event_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic event_in,
  input wire logic [3:0] reason_in,
  input wire logic [1:0] port_in,
  input wire logic clear_in,
  output logic [PEND_W-1:0] pend_out
);

  typedef struct packed {
    logic [3:0] b_reason;
    logic [1:0] b_port;
    logic b_pending;
    logic [3:0] a_reason;
    logic [1:0] a_port;
    logic a_valid;
  } slot_state_t;

  slot_state_t state_reg;
  slot_state_t state_next;

  // ---------------------------------------------------------------------------
  // capture into slot a, then slot b
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (clear_in) begin
      state_next = '0;
    end
    if (event_in && !state_next.a_valid) begin
      state_next.a_valid = 1'b1;
      state_next.a_reason = reason_in;
      state_next.a_port = port_in;
    end else if (event_in && !state_next.b_pending) begin
      state_next.b_pending = 1'b1;
      state_next.b_reason = reason_in;
      state_next.b_port = port_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pend_out = state_reg;

endmodule

// ---- tb_drop_event_report.sv ----
`timescale 1ns/100ps
`define CHECK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end

module tb_drop_event_report;
  import drop_event_pkg::*;

  // ---------------------------------------------------------------------------
  // byte addresses and expected codes
  // ---------------------------------------------------------------------------
  localparam logic [15:0] A_COUNT = {IDX_RATE_COUNT, 2'b00};
  localparam logic [15:0] A_MASK = {IDX_MASK, 2'b00};
  localparam logic [15:0] A_PEND = {IDX_PENDING, 2'b00};
  localparam logic [15:0] A_CTRL = {IDX_DROP_CTRL, 2'b00};
  localparam logic [15:0] A_NONE = {14'h1c24, 2'b00};
  localparam logic [3:0] CODES [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9};

  logic clk_in;
  logic rst_b_in;
  logic hsel_in;
  logic [15:0] haddr_in;
  logic [1:0] htrans_in;
  logic hwrite_in;
  logic [2:0] hsize_in;
  logic [31:0] hwdata_in;
  wire logic hready_in;
  logic [31:0] hrdata_out;
  logic hreadyout_out;
  logic hresp_out;
  logic drop_valid_in;
  logic [7:0] drop_cause_in;
  logic [1:0] drop_port_in;
  logic [11:0] drop_len_in;
  logic irq_out;
  int fails;
  int num_checks;

  assign hready_in = hreadyout_out;

  drop_event_report drop_event_report_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
    .hwdata_in(hwdata_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .drop_valid_in(drop_valid_in),
    .drop_cause_in(drop_cause_in), .drop_port_in(drop_port_in), .drop_len_in(drop_len_in),
    .irq_out(irq_out)
  );

  always #25 clk_in = ~clk_in;

  // ---------------------------------------------------------------------------
  // bus and event drivers
  // ---------------------------------------------------------------------------
  task automatic bus(input logic wr, input logic [15:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= addr;
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    hsize_in <= 3'b010;
    do begin
      @(posedge clk_in);
    end while (hready_in !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    do begin
      @(posedge clk_in);
    end while (hready_in !== 1'b1);
    rd = hrdata_out;
  endtask

  task automatic wr(input logic [15:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, addr, wd, rd);
  endtask

  task automatic rd_check(input logic [15:0] addr, input logic [31:0] exp, input string what);
    logic [31:0] rd;
    bus(1'b0, addr, 32'h0000_0000, rd);
    `CHECK(what, exp, rd)
  endtask

  task automatic drop(input logic [7:0] c, input logic [1:0] p, input logic [11:0] l);
    @(posedge clk_in);
    drop_valid_in <= 1'b1;
    drop_cause_in <= c;
    drop_port_in <= p;
    drop_len_in <= l;
    @(posedge clk_in);
    drop_valid_in <= 1'b0;
  endtask

  task automatic irq_check(input logic exp);
    @(posedge clk_in);
    #1 `CHECK("irq", exp, irq_out)
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic s_reset;
    rd_check(A_COUNT, 32'h0000_0000, "count reset");
    rd_check(A_MASK, 32'h0000_0001, "mask reset");
    rd_check(A_PEND, 32'h0000_0000, "pending reset");
    rd_check(A_NONE, 32'h0000_0000, "unmapped");
    `CHECK("hresp", 1'b0, hresp_out)
    drop(8'h02, 2'b10, 12'h064);
    rd_check(A_PEND, 32'h0000_0000, "red disabled");
    rd_check(A_COUNT, 32'h0000_0000, "red disabled count");
  endtask

  task automatic s_reasons;
    wr(A_CTRL, 32'h0000_0003);
    for (int i = 0; i < 8; i++) begin
      drop(8'h01 << i, 2'(i % 3), 12'h041);
      irq_check(1'b0);
      rd_check(A_PEND, {25'h0, CODES[i], 2'(i % 3), 1'b1}, "slot a");
    end
    drop(8'h20, 2'b00, 12'h040);
    rd_check(A_PEND, 32'h0000_0000, "rx error 64");
    drop(8'h22, 2'b01, 12'h040);
    rd_check(A_PEND, {25'h0, 4'h1, 2'b01, 1'b1}, "rx error skipped");
    drop(8'h04, 2'b11, 12'h041);
    rd_check(A_PEND, 32'h0000_0000, "reserved port");
  endtask

  task automatic s_double;
    wr(A_MASK, 32'hffff_fffe);
    rd_check(A_MASK, 32'h0000_0000, "mask clear");
    drop(8'h04, 2'b00, 12'h041);
    irq_check(1'b1);
    @(posedge clk_in);
    drop_valid_in <= 1'b1;
    drop_cause_in <= 8'h08;
    drop_port_in <= 2'b01;
    @(posedge clk_in);
    drop_cause_in <= 8'h40;
    drop_port_in <= 2'b10;
    @(posedge clk_in);
    drop_valid_in <= 1'b0;
    rd_check(A_PEND, {18'h0, 4'h3, 2'b01, 1'b1, 4'h2, 2'b00, 1'b1}, "both slots");
    irq_check(1'b0);
    rd_check(A_PEND, 32'h0000_0000, "pending cleared");
    drop(8'h80, 2'b10, 12'h041);
    irq_check(1'b1);
    wr(A_MASK, 32'hffff_ffff);
    rd_check(A_MASK, 32'h0000_0001, "mask set");
    irq_check(1'b0);
    rd_check(A_PEND, {25'h0, 4'h9, 2'b10, 1'b1}, "kept under mask");
  endtask

  task automatic s_counter;
    wr(A_CTRL, 32'h0000_0003);
    rd_check(A_COUNT, 32'h0000_0001, "count of yellow");
    drop(8'h02, 2'b10, 12'h041);
    drop(8'h80, 2'b10, 12'h041);
    drop(8'h80, 2'b10, 12'h041);
    drop(8'h02, 2'b01, 12'h041);
    drop(8'h04, 2'b10, 12'h041);
    rd_check(A_COUNT, 32'h0000_0003, "count");
    rd_check(A_COUNT, 32'h0000_0000, "count cleared");
    rd_check(A_PEND, {18'h0, 4'h9, 2'b10, 1'b1, 4'h1, 2'b10, 1'b1}, "slots full");
    fork
      rd_check(A_COUNT, 32'h0000_0000, "count read at drop");
      drop(8'h02, 2'b10, 12'h041);
    join
    rd_check(A_COUNT, 32'h0000_0001, "count survives read");
    fork
      rd_check(A_PEND, {25'h0, 4'h1, 2'b10, 1'b1}, "pending read at drop");
      drop(8'h04, 2'b00, 12'h041);
    join
    rd_check(A_PEND, {25'h0, 4'h2, 2'b00, 1'b1}, "event survives read");
  endtask

  task automatic finish_test;
    $display("Checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    rst_b_in = 1'b0;
    hsel_in = 1'b0;
    haddr_in = 16'h0000;
    htrans_in = 2'b00;
    hwrite_in = 1'b0;
    hsize_in = 3'b010;
    hwdata_in = 32'h0000_0000;
    drop_valid_in = 1'b0;
    drop_cause_in = 8'h00;
    drop_port_in = 2'b00;
    drop_len_in = 12'h000;
    fails = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_in);
    rst_b_in <= 1'b1;
    s_reset();
    s_reasons();
    s_double();
    s_counter();
    finish_test();
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    finish_test();
  end
endmodule
